// file: design/jcpp_pkg.sv
// Overview of operation
// R1 - Instruction register is eight bits; every opcode shifts in as eight bits.
// R2 - Opcodes with the top bit set act as bypass, one-bit register in path.
// R3 - Opcode 0x00 enters external test mode with the boundary chain in path.
// R4 - Opcode 0x1C puts the boundary chain in path to capture pin states.
// R5 - Opcode 0x16 selects the 32-bit identification register; device runs normally.
// R6 - After reset or Test-Logic-Reset a data scan reads the identification register.
// R7 - Opcode 0x15 enters programming mode; opcode 0x1E leaves it.
// R8 - Opcode 0x03 erases whole array, signature and lock; only in programming mode.
// R9 - Host erases the whole array before writing a new configuration.
// R10 - Opcode 0x01 selects the 10-bit column address register.
// R11 - Opcode 0x02 selects the column data register for shifting.
// R12 - Opcode 0x07 writes column data to the addressed column in programming mode.
// R13 - Opcode 0x27 writes the addressed column then increments the address.
// R14 - Opcode 0x0A loads the addressed column into column data in programming mode.
// R15 - Opcode 0x2A loads the addressed column then increments the address.
// R16 - Opcode 0x09 sets the readout lock; only erase clears it; blocks column reads. The code also clears it on rstn_in reset.
// R17 - Opcode 0x17 copies the stored user signature in and selects it.
// R18 - Opcode 0x1A stores the user signature register in programming mode.
// R19 - Opcode 0x14 discharges the programming supply; host issues it after writes.
// R20 - Opcode 0x18 holds all outputs high impedance while active.
// R21 - Opcodes 0x20 and 0x30 drive pins from the boundary chain.
// R22 - Opcode 0x22 resets all user logic like the external reset pin.
// R23 - Opcode 0x24 clears the config valid bit; opcode 0x2F sets it.
// R24 - Array operations start on entry to Run-Test/Idle; others act in Update.
// R25 - Capture-IR always loads the identification opcode into the shift path.
// R26 - TDI and TMS sampled on rising TCK; TDO changes on falling TCK.
// R27 - Unlisted opcodes with top bit clear act as bypass. The code decodes unlisted 0x2C as INTEST with the boundary chain in path.
package jcpp_pkg;

localparam int IR_W = 8;
localparam int CADDR_W = 10;
localparam int CDATA_W = 89;
localparam int ID_W = 32;
localparam int USIG_W = 32;
localparam int NCOLS = 1 << CADDR_W;

localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
localparam logic [IR_W-1:0] OP_ADDR = 8'h01;
localparam logic [IR_W-1:0] OP_DATA = 8'h02;
localparam logic [IR_W-1:0] OP_ERASE = 8'h03;
localparam logic [IR_W-1:0] OP_WRITE = 8'h07;
localparam logic [IR_W-1:0] OP_LOCK = 8'h09;
localparam logic [IR_W-1:0] OP_READ = 8'h0A;
localparam logic [IR_W-1:0] OP_DROP_VPP = 8'h14;
localparam logic [IR_W-1:0] OP_PROG_ON = 8'h15;
localparam logic [IR_W-1:0] OP_IDCODE = 8'h16;
localparam logic [IR_W-1:0] OP_USERCODE = 8'h17;
localparam logic [IR_W-1:0] OP_WRITE_SIG = 8'h1A;
localparam logic [IR_W-1:0] OP_PROG_OFF = 8'h1E;
localparam logic [IR_W-1:0] OP_HIGHZ = 8'h18;
localparam logic [IR_W-1:0] OP_SAMPLE = 8'h1C;
localparam logic [IR_W-1:0] OP_CLAMP = 8'h20;
localparam logic [IR_W-1:0] OP_USER_RST = 8'h22;
localparam logic [IR_W-1:0] OP_INTEST = 8'h2C;
localparam logic [IR_W-1:0] OP_CLR_VALID = 8'h24;
localparam logic [IR_W-1:0] OP_WRITE_INC = 8'h27;
localparam logic [IR_W-1:0] OP_READ_INC = 8'h2A;
localparam logic [IR_W-1:0] OP_SET_VALID = 8'h2F;
localparam logic [IR_W-1:0] OP_CLAMP_ALIAS = 8'h30;

localparam logic RST_PROG = 1'b0;
localparam logic RST_SUPPLY = 1'b0;
localparam logic RST_LOCK = 1'b0;
localparam logic RST_VALID = 1'b0;
localparam logic [USIG_W-1:0] RST_USIG = 32'h0000_0000;

typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
} jcpp_tap_t;

typedef enum logic [4:0] {
    I_BYPASS, I_EXTEST, I_SAMPLE, I_INTEST, I_IDCODE, I_PROG_ON, I_PROG_OFF, I_ERASE,
    I_ADDR, I_DATA, I_WRITE, I_WRITE_INC, I_READ, I_READ_INC, I_LOCK, I_USERCODE,
    I_WRITE_SIG, I_DROP_VPP, I_HIGHZ, I_CLAMP, I_USER_RST, I_CLR_VALID, I_SET_VALID
} jcpp_instr_t;

typedef enum logic [2:0] {DR_BYP, DR_BSR, DR_ID, DR_ADDR, DR_COL, DR_USIG} jcpp_path_t;

typedef struct packed {
    logic select;
    logic capture;
    logic shift;
    logic update;
    logic tdi;
} jcpp_bsr_t;

typedef struct packed {
    logic extest;
    logic highz;
    logic clamp;
    logic user_reset;
    logic prog_mode;
    logic prog_supply;
    logic config_valid;
    logic readout_lock;
} jcpp_mode_t;

endpackage

// file: design/jcpp_tap.sv
`timescale 1ns/1ns
module jcpp_tap
    import jcpp_pkg::*;
#(
    // Arbitrary identification value
    parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_0001
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    input wire logic bsr_so_in,
    output jcpp_bsr_t bsr_ctl_out,
    output jcpp_mode_t mode_out
);

typedef struct packed {
    logic tck_m;
    logic tck_s;
    logic tck_d;
    logic tms_m;
    logic tms_s;
    logic tdi_m;
    logic tdi_s;
    jcpp_tap_t tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic [ID_W-1:0] id_sh;
    logic byp;
    logic [CADDR_W-1:0] addr;
    logic [CDATA_W-1:0] cdr;
    logic [USIG_W-1:0] usr;
    logic [USIG_W-1:0] usr_nv;
    logic prog;
    logic supply;
    logic lock;
    logic valid;
    logic tdo;
    logic tdo_oe;
} jcpp_state_t;

jcpp_state_t s_r;
jcpp_state_t s_nxt;
logic [CDATA_W-1:0] col_mem [NCOLS];
logic [CDATA_W-1:0] col_rd;
logic col_we;
logic col_clr;
logic tck_rise;
logic tck_fall;
jcpp_instr_t cur_instr;
jcpp_instr_t new_instr;
jcpp_path_t path;
logic dr_so;

function automatic jcpp_instr_t decode(input logic [IR_W-1:0] op);
    jcpp_instr_t r;
    r = I_BYPASS;
    if (!op[IR_W-1]) begin // R2
        case (op)
            OP_EXTEST: r = I_EXTEST; // R3
            OP_SAMPLE: r = I_SAMPLE; // R4
            OP_INTEST: r = I_INTEST;
            OP_IDCODE: r = I_IDCODE; // R5
            OP_PROG_ON: r = I_PROG_ON; // R7
            OP_PROG_OFF: r = I_PROG_OFF; // R7
            OP_ERASE: r = I_ERASE; // R8
            OP_ADDR: r = I_ADDR; // R10
            OP_DATA: r = I_DATA; // R11
            OP_WRITE: r = I_WRITE; // R12
            OP_WRITE_INC: r = I_WRITE_INC; // R13
            OP_READ: r = I_READ; // R14
            OP_READ_INC: r = I_READ_INC; // R15
            OP_LOCK: r = I_LOCK; // R16
            OP_USERCODE: r = I_USERCODE; // R17
            OP_WRITE_SIG: r = I_WRITE_SIG; // R18
            OP_DROP_VPP: r = I_DROP_VPP; // R19
            OP_HIGHZ: r = I_HIGHZ; // R20
            OP_CLAMP, OP_CLAMP_ALIAS: r = I_CLAMP; // R21
            OP_USER_RST: r = I_USER_RST; // R22
            OP_CLR_VALID: r = I_CLR_VALID; // R23
            OP_SET_VALID: r = I_SET_VALID; // R23
            default: r = I_BYPASS; // R27
        endcase
    end
    return r;
endfunction

function automatic jcpp_tap_t tap_next(input jcpp_tap_t st, input logic tms);
    jcpp_tap_t r;
    r = TAP_RESET;
    case (st)
        TAP_RESET: r = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: r = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: r = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: r = tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR: r = tms ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: r = tms ? TAP_UPD_DR : TAP_PA_DR;
        TAP_PA_DR: r = tms ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: r = tms ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR: r = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: r = tms ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: r = tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR: r = tms ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: r = tms ? TAP_UPD_IR : TAP_PA_IR;
        TAP_PA_IR: r = tms ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: r = tms ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR: r = tms ? TAP_SEL_DR : TAP_IDLE;
        default: r = TAP_RESET;
    endcase
    return r;
endfunction

// Edges of TCK seen after the two-stage synchroniser
assign tck_rise = s_r.tck_s & ~s_r.tck_d; // R26
assign tck_fall = ~s_r.tck_s & s_r.tck_d; // R26
assign cur_instr = decode(s_r.ir);
assign col_rd = col_mem[s_r.addr];

always_comb begin
    case (cur_instr)
        I_EXTEST, I_SAMPLE, I_INTEST, I_CLAMP: path = DR_BSR; // R3 R4 R21
        I_IDCODE: path = DR_ID; // R5
        I_ADDR: path = DR_ADDR; // R10
        I_DATA, I_WRITE, I_WRITE_INC, I_READ, I_READ_INC: path = DR_COL; // R11
        I_USERCODE: path = DR_USIG; // R17
        default: path = DR_BYP; // R2
    endcase
end

always_comb begin
    case (path)
        DR_BSR: dr_so = bsr_so_in;
        DR_ID: dr_so = s_r.id_sh[0];
        DR_ADDR: dr_so = s_r.addr[0];
        DR_COL: dr_so = s_r.cdr[0];
        DR_USIG: dr_so = s_r.usr[0];
        default: dr_so = s_r.byp;
    endcase
end

always_comb begin
    s_nxt = s_r;
    col_we = 1'b0;
    col_clr = 1'b0;
    new_instr = cur_instr;
    s_nxt.tck_m = tck_in;
    s_nxt.tck_s = s_r.tck_m;
    s_nxt.tck_d = s_r.tck_s;
    s_nxt.tms_m = tms_in;
    s_nxt.tms_s = s_r.tms_m;
    s_nxt.tdi_m = tdi_in;
    s_nxt.tdi_s = s_r.tdi_m;
    if (tck_rise) begin
        s_nxt.tap = tap_next(s_r.tap, s_r.tms_s); // R26
        case (s_r.tap)
            TAP_RESET: begin
                s_nxt.ir = OP_IDCODE; // R6
            end
            TAP_CAP_IR: begin
                s_nxt.ir_sh = OP_IDCODE; // R25
            end
            TAP_SH_IR: begin
                s_nxt.ir_sh = {s_r.tdi_s, s_r.ir_sh[IR_W-1:1]}; // R1
            end
            TAP_UPD_IR: begin
                s_nxt.ir = s_r.ir_sh; // R1
                case (decode(s_r.ir_sh))
                    I_PROG_ON: s_nxt.prog = 1'b1; // R7
                    I_PROG_OFF: s_nxt.prog = 1'b0; // R7
                    I_DROP_VPP: s_nxt.supply = 1'b0; // R19
                    I_USERCODE: s_nxt.usr = s_r.usr_nv; // R17
                    default: s_nxt.prog = s_r.prog;
                endcase
            end
            TAP_CAP_DR: begin
                case (path)
                    DR_ID: s_nxt.id_sh = ID_VALUE; // R5 R6
                    DR_USIG: s_nxt.usr = s_r.usr_nv; // R17
                    DR_BYP: s_nxt.byp = 1'b0; // R2
                    default: s_nxt.byp = s_r.byp;
                endcase
            end
            TAP_SH_DR: begin
                case (path)
                    DR_ID: s_nxt.id_sh = {s_r.tdi_s, s_r.id_sh[ID_W-1:1]}; // R5
                    DR_ADDR: s_nxt.addr = {s_r.tdi_s, s_r.addr[CADDR_W-1:1]}; // R10
                    DR_COL: s_nxt.cdr = {s_r.tdi_s, s_r.cdr[CDATA_W-1:1]}; // R11
                    DR_USIG: s_nxt.usr = {s_r.tdi_s, s_r.usr[USIG_W-1:1]}; // R17
                    DR_BYP: s_nxt.byp = s_r.tdi_s; // R2 R27
                    default: s_nxt.byp = s_r.byp;
                endcase
            end
            default: begin
                s_nxt.byp = s_r.byp;
            end
        endcase
        // Array work runs on each entry into Run-Test/Idle, only in programming mode
        new_instr = decode(s_nxt.ir);
        if (s_nxt.tap == TAP_IDLE && s_r.tap != TAP_IDLE && s_nxt.prog) begin // R24
            case (new_instr)
                I_ERASE: begin
                    col_clr = 1'b1; // R8
                    s_nxt.usr_nv = RST_USIG; // R8
                    s_nxt.lock = 1'b0; // R8 R16
                    s_nxt.valid = 1'b0; // R8
                    s_nxt.supply = 1'b1;
                end
                I_WRITE: begin
                    col_we = 1'b1; // R12
                    s_nxt.supply = 1'b1;
                end
                I_WRITE_INC: begin
                    col_we = 1'b1; // R13
                    s_nxt.addr = CADDR_W'(s_r.addr + 1'b1); // R13
                    s_nxt.supply = 1'b1;
                end
                I_READ: begin
                    s_nxt.cdr = s_r.lock ? '0 : col_rd; // R14 R16
                end
                I_READ_INC: begin
                    s_nxt.cdr = s_r.lock ? '0 : col_rd; // R15 R16
                    s_nxt.addr = CADDR_W'(s_r.addr + 1'b1); // R15
                end
                I_LOCK: begin
                    s_nxt.lock = 1'b1; // R16
                    s_nxt.supply = 1'b1;
                end
                I_WRITE_SIG: begin
                    s_nxt.usr_nv = s_r.usr; // R18
                    s_nxt.supply = 1'b1;
                end
                I_CLR_VALID: begin
                    s_nxt.valid = 1'b0; // R23
                    s_nxt.supply = 1'b1;
                end
                I_SET_VALID: begin
                    s_nxt.valid = 1'b1; // R23
                    s_nxt.supply = 1'b1;
                end
                default: begin
                    s_nxt.valid = s_r.valid;
                end
            endcase
        end
    end
    if (tck_fall) begin
        s_nxt.tdo_oe = (s_r.tap == TAP_SH_DR) || (s_r.tap == TAP_SH_IR); // R26
        s_nxt.tdo = (s_r.tap == TAP_SH_IR) ? s_r.ir_sh[0] : dr_so; // R26
    end
end

always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
        s_r <= '0;
        s_r.tap <= TAP_RESET;
        s_r.ir <= OP_IDCODE; // R6
        s_r.ir_sh <= OP_IDCODE;
        s_r.prog <= RST_PROG;
        s_r.supply <= RST_SUPPLY;
        s_r.lock <= RST_LOCK;
        s_r.valid <= RST_VALID;
        s_r.usr_nv <= RST_USIG;
    end else begin
        s_r <= s_nxt;
    end
end

// Column array keeps its content through reset, as the cells it stands for
always_ff @(posedge clk_in) begin
    if (col_clr) begin
        for (int i = 0; i < NCOLS; i++) begin
            col_mem[i] <= '0; // R8
        end
    end else if (col_we) begin
        col_mem[s_r.addr] <= s_r.cdr; // R12 R13
    end
end

assign tdo_out = s_r.tdo;
assign tdo_oe_out = s_r.tdo_oe;

assign bsr_ctl_out.select = (path == DR_BSR);
assign bsr_ctl_out.capture = tck_rise && (s_r.tap == TAP_CAP_DR) && (path == DR_BSR); // R4
assign bsr_ctl_out.shift = tck_rise && (s_r.tap == TAP_SH_DR) && (path == DR_BSR); // R3 R4
assign bsr_ctl_out.update = tck_rise && (s_r.tap == TAP_UPD_DR) && (path == DR_BSR);
assign bsr_ctl_out.tdi = s_r.tdi_s;

assign mode_out.extest = (cur_instr == I_EXTEST); // R3
assign mode_out.highz = (cur_instr == I_HIGHZ); // R20
assign mode_out.clamp = (cur_instr == I_CLAMP); // R21
assign mode_out.user_reset = (cur_instr == I_USER_RST); // R22
assign mode_out.prog_mode = s_r.prog;
assign mode_out.prog_supply = s_r.supply;
assign mode_out.config_valid = s_r.valid;
assign mode_out.readout_lock = s_r.lock;

endmodule

// file: verification/jcpp_host.sv
`timescale 1ns/1ns
module jcpp_host (
    input wire logic clk_in,
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One 80 ns TCK period; TDO taken just before the rise that shifts
    task automatic tick(input logic m, input logic d, output logic q);
        tms_out <= m;
        tdi_out <= d;
        repeat (10) @(posedge clk_in);
        q = tdo_in;
        tck_out <= 1'b1;
        repeat (10) @(posedge clk_in);
        tck_out <= 1'b0;
    endtask
    // Outside shifts TDI carries no data, so it flips every period
    task automatic move(input logic m);
        logic q;
        tick(m, ~tdi_out, q);
    endtask
    // From Run-Test/Idle: n bits LSB first, back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [88:0] din, output logic [88:0] dout);
        logic q;
        dout = '0;
        move(1'b1);
        if (ir) begin
            move(1'b1);
        end
        move(1'b0);
        move(1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        move(1'b1);
        move(1'b0);
    endtask
    task automatic reset_tap;
        repeat (5) move(1'b1);
        move(1'b0);
    endtask
endmodule

// file: verification/jcpp_tap_chk.sv
`timescale 1ns/1ns
module jcpp_tap_chk
    import jcpp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic bsr_so_in,
    input wire jcpp_bsr_t bsr_ctl_out,
    input wire jcpp_mode_t mode_out
);
    logic [2:0] sync_r;
    logic [3:0] rise_r;
    logic [3:0] fall_r;
    logic pulse;
    logic [3:0] lvl;
    assign pulse = bsr_ctl_out.capture | bsr_ctl_out.shift | bsr_ctl_out.update;
    assign lvl = {mode_out.extest, mode_out.highz, mode_out.clamp, mode_out.user_reset};
    // Cycles since the synchronised TCK edges, saturating
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_r <= 3'h0;
            rise_r <= 4'hF;
            fall_r <= 4'hF;
        end else begin
            sync_r <= {sync_r[1:0], tck_in};
            rise_r <= (sync_r[2:1] == 2'h1) ? 4'h0 : rise_r + {3'h0, ~&rise_r};
            fall_r <= (sync_r[2:1] == 2'h2) ? 4'h0 : fall_r + {3'h0, ~&fall_r};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_TDO_AT_FALL: assert property ($changed(tdo_out) |-> fall_r <= 4'h6)
        else $error("tdo moved away from a tck fall");
    AST_OE_AT_FALL: assert property ($changed(tdo_oe_out) |-> fall_r <= 4'h6)
        else $error("tdo enable moved away from a tck fall");
    AST_PULSE_AT_RISE: assert property (pulse |-> sync_r[2:1] == 2'h1 && bsr_ctl_out.select)
        else $error("chain pulse off a tck rise or unselected");
    AST_PULSE_SHORT: assert property ((bsr_ctl_out.capture || bsr_ctl_out.update) |=> !pulse)
        else $error("chain pulse longer than one cycle");
    AST_MODE_AT_RISE: assert property ($changed({lvl, mode_out.prog_mode}) |-> rise_r <= 4'h4)
        else $error("mode changed away from a tck rise");
    AST_ONE_MODE: assert property ($onehot0(lvl))
        else $error("several pin modes at once");
    AST_CHAIN_MODES: assert property ((mode_out.extest || mode_out.clamp) |-> bsr_ctl_out.select)
        else $error("chain not selected in extest or clamp");
    AST_LOCK_NEEDS_PROG: assert property ($changed(mode_out.readout_lock) |-> mode_out.prog_mode)
        else $error("lock changed outside programming mode");
    AST_VALID_NEEDS_PROG: assert property ($changed(mode_out.config_valid) |-> mode_out.prog_mode)
        else $error("valid bit changed outside programming mode");
    AST_SUPPLY_NEEDS_PROG: assert property ($rose(mode_out.prog_supply) |-> $past(mode_out.prog_mode, 1))
        else $error("supply charged outside programming mode");
    COV_SHIFT: cover property (bsr_ctl_out.shift);
    COV_LOCK: cover property ($rose(mode_out.readout_lock));
    COV_OE: cover property ($rose(tdo_oe_out));
endmodule
bind jcpp_tap jcpp_tap_chk jcpp_tap_chk_i (.clk_in(clk_in), .rstn_in(rstn_in), .tck_in(tck_in),
    .tms_in(tms_in), .tdi_in(tdi_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .bsr_so_in(bsr_so_in), .bsr_ctl_out(bsr_ctl_out), .mode_out(mode_out));

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    import jcpp_pkg::*;
    localparam logic [31:0] ID = 32'h0000_0A5B; // Arbitrary value
    localparam logic [88:0] PA = 89'h1_0123_4567_89AB_CDEF_0123_45;
    localparam logic [88:0] PB = ~PA;
    localparam logic [88:0] PC = {PA[44:0], PA[88:45]};
    localparam logic [88:0] SIG = 89'hC0DE_5A17;
    logic clk_in, rstn_in, tck, tms, tdi, tdo, tdo_oe, bsr_so, tdo_pin;
    logic [3:0] upd_r = 4'h0;
    jcpp_bsr_t bsr;
    jcpp_mode_t mode, em;
    logic [3:0] chain_r = 4'h0;
    int err_total = 0;
    int check_count = 0;
    logic [7:0] byp[4] = '{8'hFF, 8'h80, 8'h05, 8'h7F};
    logic [7:0] bop[7] = '{OP_EXTEST, OP_SAMPLE, OP_CLAMP, OP_CLAMP_ALIAS, OP_HIGHZ, OP_USER_RST, OP_INTEST};
    logic [4:0] bexp[7] = '{5'h18, 5'h10, 5'h12, 5'h12, 5'h04, 5'h01, 5'h10};
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Four-cell boundary chain standing outside the block
    always @(posedge clk_in) begin
        if (bsr.capture) chain_r <= 4'h9;
        else if (bsr.shift) chain_r <= {bsr.tdi, chain_r[3:1]};
        if (bsr.update) upd_r <= chain_r;
    end
    assign bsr_so = chain_r[0];
    // Released TDO pin is pulled up
    assign tdo_pin = tdo_oe ? tdo : 1'b1;
    jcpp_host host_i (.clk_in(clk_in), .tdo_in(tdo_pin), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
    jcpp_tap #(.ID_VALUE(ID)) jcpp_tap_i (.clk_in(clk_in), .rstn_in(rstn_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .bsr_so_in(bsr_so), .bsr_ctl_out(bsr), .mode_out(mode));
    task automatic chk(input logic [88:0] got, input logic [88:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_mode;
        chk(89'(mode), 89'(em));
    endtask
    task automatic ir(input logic [7:0] op);
        logic [88:0] o;
        host_i.scan(1'b1, 8, {81'h0, op}, o);
        chk(o, 89'h16);
    endtask
    task automatic put(input int n, input logic [88:0] din);
        logic [88:0] o;
        host_i.scan(1'b0, n, din, o);
    endtask
    task automatic dr(input int n, input logic [88:0] din, input logic [88:0] exp);
        logic [88:0] o;
        host_i.scan(1'b0, n, din, o);
        chk(o, exp);
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        rstn_in = 1'b0;
        em = '0;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk_mode();
        host_i.reset_tap();
        dr(32, 89'h0, ID);
        foreach (byp[k]) begin
            ir(byp[k]);
            dr(2, 89'h1, 89'h2);
        end
        ir(OP_IDCODE);
        dr(32, 89'h0, ID);
        chk_mode();
        note("identify");
        foreach (bop[k]) begin
            ir(bop[k]);
            chk(89'({bsr.select, mode.extest, mode.highz, mode.clamp, mode.user_reset}), 89'(bexp[k]));
            if (bexp[k][4]) begin
                dr(4, 89'h6, 89'h9);
                chk(89'(upd_r), 89'h6);
            end
        end
        ir(OP_SET_VALID);
        chk_mode();
        note("boundary");
        ir(OP_PROG_ON);
        em.prog_mode = 1'b1;
        chk_mode();
        ir(OP_ERASE);
        em.prog_supply = 1'b1;
        chk_mode();
        ir(OP_ADDR);
        put(10, 89'd1022);
        ir(OP_DATA);
        put(89, PA);
        ir(OP_WRITE_INC);
        ir(OP_DATA);
        put(89, PB);
        ir(OP_WRITE);
        ir(OP_ADDR);
        put(10, 89'd1022);
        ir(OP_READ_INC);
        dr(89, 89'h0, PA);
        dr(89, 89'h0, PB);
        note("columns");
        ir(OP_USERCODE);
        dr(32, SIG, 89'h0);
        ir(OP_WRITE_SIG);
        ir(OP_USERCODE);
        dr(32, 89'h0, SIG);
        ir(OP_SET_VALID);
        em.config_valid = 1'b1;
        chk_mode();
        ir(OP_CLR_VALID);
        em.config_valid = 1'b0;
        chk_mode();
        ir(OP_LOCK);
        em.readout_lock = 1'b1;
        chk_mode();
        ir(OP_ADDR);
        put(10, 89'd1022);
        ir(OP_READ);
        dr(89, 89'h0, 89'h0);
        ir(OP_USERCODE);
        dr(32, 89'h0, SIG);
        ir(OP_ERASE);
        em.readout_lock = 1'b0;
        chk_mode();
        ir(OP_USERCODE);
        dr(32, 89'h0, 89'h0);
        ir(OP_DROP_VPP);
        em.prog_supply = 1'b0;
        chk_mode();
        ir(OP_PROG_OFF);
        em.prog_mode = 1'b0;
        chk_mode();
        note("program");
        ir(OP_DATA);
        put(89, PC);
        ir(OP_READ);
        dr(89, 89'h0, PC);
        ir(OP_LOCK);
        chk_mode();
        host_i.reset_tap();
        dr(32, 89'h0, ID);
        note("refuse");
        conclude();
    end
    initial begin
        #300000;
        err_total++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end
endmodule
